//--- logic/cap_regs_pkg.sv
// Package with addresses, field layout and fixed values of the capability registers
package cap_regs_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	localparam logic [7:0] CAP_TWO_LOW_ADDR = 8'h26;
	localparam logic [7:0] CAP_TWO_HIGH_ADDR = 8'h27;
	localparam logic [7:0] STD_IN_CAP_ADDR = 8'h28;
	localparam logic [7:0] STD_OUT_CAP_ADDR = 8'h29;

	localparam logic [7:0] CAP_TWO_LOW_RESET = 8'hc5;
	localparam logic [7:0] CAP_TWO_HIGH_RESET = 8'h00;
	localparam logic [7:0] STD_IN_CAP_RESET = 8'h00;
	localparam logic [7:0] STD_OUT_CAP_RESET = 8'h00;
	localparam logic [7:0] READ_ZERO = 8'h00;

	// Field positions in the low capability byte
	localparam int SINK_DISC_BIT = 7;
	localparam int STOP_DISCH_BIT = 6;
	localparam int ALARM_STEP_HI = 5;
	localparam int ALARM_STEP_LO = 4;
	localparam int POWER_CLASS_HI = 3;
	localparam int POWER_CLASS_LO = 1;
	localparam int OC_CAPABLE_BIT = 0;

	// Field positions in the standard input capability byte
	localparam int EXT_OVERVOLT_BIT = 2;
	localparam int EXT_OVERCUR_BIT = 1;
	localparam int EXT_CUT_BIT = 0;

	typedef enum logic [1:0] {
		STEP_25MV = 2'h0,
		STEP_50MV = 2'h1,
		STEP_100MV = 2'h2,
		STEP_RSVD = 2'h3
	} alarm_step_e;

	typedef enum logic [2:0] {
		PWR_1W0 = 3'h0,
		PWR_1W5 = 3'h1,
		PWR_2W0 = 3'h2,
		PWR_3W0 = 3'h3,
		PWR_4W0 = 3'h4,
		PWR_5W0 = 3'h5,
		PWR_6W0 = 3'h6,
		PWR_EXT = 3'h7
	} power_class_e;

	// Implemented capability values
	localparam logic SINK_DISC_VAL = 1'h1;
	localparam logic STOP_DISCH_VAL = 1'h1;
	localparam alarm_step_e ALARM_STEP_VAL = STEP_25MV;
	localparam power_class_e POWER_CLASS_VAL = PWR_2W0;
	localparam logic OC_CAPABLE_VAL = 1'h1;
	localparam logic EXT_OVERVOLT_VAL = 1'h0;
	localparam logic EXT_OVERCUR_VAL = 1'h0;
	localparam logic EXT_CUT_VAL = 1'h0;

	localparam logic [1:0] IGNORE_NONE = 2'h0;
	localparam logic [1:0] IGNORE_BIT0 = 2'h1;
	localparam logic [1:0] IGNORE_BITS10 = 2'h3;
	localparam logic [7:0] DECIWATT_EXT = 8'hff;

	// Threshold bits that the alarm comparator skips for a step code
	function automatic logic [1:0] ignoreMask(input alarm_step_e step);
		case (step)
			STEP_25MV: ignoreMask = IGNORE_NONE;
			STEP_50MV: ignoreMask = IGNORE_BIT0;
			STEP_100MV: ignoreMask = IGNORE_BITS10;
			default: ignoreMask = IGNORE_NONE;
		endcase
	endfunction : ignoreMask

	// Cable supply switch rating in tenths of a watt
	function automatic logic [7:0] powerDeciwatts(input power_class_e cls);
		case (cls)
			PWR_1W0: powerDeciwatts = 8'h0a;
			PWR_1W5: powerDeciwatts = 8'h0f;
			PWR_2W0: powerDeciwatts = 8'h14;
			PWR_3W0: powerDeciwatts = 8'h1e;
			PWR_4W0: powerDeciwatts = 8'h28;
			PWR_5W0: powerDeciwatts = 8'h32;
			PWR_6W0: powerDeciwatts = 8'h3c;
			default: powerDeciwatts = DECIWATT_EXT;
		endcase
	endfunction : powerDeciwatts
endpackage : cap_regs_pkg

//--- logic/cap_field_if.sv
// Interface carrying the packed capability byte and its decoded meaning
`timescale 1ns/1ns
interface cap_field_if;
	logic [7:0] capLowByte;
	logic [7:0] stdInByte;
	logic [1:0] ignoreMask;
	logic [7:0] deciwatts;

	modport packer (output capLowByte, output stdInByte, output ignoreMask, output deciwatts);
	modport user (input capLowByte, input stdInByte, input ignoreMask, input deciwatts);
endinterface : cap_field_if

//--- logic/cap_byte_pack.sv
// Packs capability fields into register bytes and decodes their meaning
`timescale 1ns/1ns
module cap_byte_pack (
	cap_field_if.packer fields
);
	wire logic [1:0] stepCode;
	wire logic [2:0] powerCode;

	assign stepCode = cap_regs_pkg::ALARM_STEP_VAL; // [R3]
	assign powerCode = cap_regs_pkg::POWER_CLASS_VAL; // [R5]

	assign fields.capLowByte = {cap_regs_pkg::SINK_DISC_VAL, // [R1]
		cap_regs_pkg::STOP_DISCH_VAL, // [R2]
		stepCode,
		powerCode,
		cap_regs_pkg::OC_CAPABLE_VAL}; // [R6]
	assign fields.stdInByte = {5'h00, cap_regs_pkg::EXT_OVERVOLT_VAL,
		cap_regs_pkg::EXT_OVERCUR_VAL, cap_regs_pkg::EXT_CUT_VAL}; // [R8]
	assign fields.ignoreMask = cap_regs_pkg::ignoreMask(cap_regs_pkg::alarm_step_e'(stepCode)); // [R4]
	assign fields.deciwatts = cap_regs_pkg::powerDeciwatts(cap_regs_pkg::power_class_e'(powerCode)); // [R5]
endmodule : cap_byte_pack

//--- logic/port_controller_capability_regs.sv
// Read-only capability register bank with a simple byte register port
`timescale 1ns/1ns
// Function
// (R1) Bit 7 reads 1: sink disconnect threshold
// (R2) Bit 6 reads 1: stop discharge threshold
// (R3) Bits 5:4 read 00: 25 mV alarm step
// (R4) Step codes: 01 skips bit0, 10 skips 1:0
// (R5) Bits 3:1 read 010: 2 W supply switch
// (R6) Bit 0 reads 1: overcurrent fault capable
// (R7) Address 0x27 always reads zero
// (R8) Address 0x28 reads zero, no external inputs
// (R9) Address 0x29 reads zero, no indicator outputs
// (R10) Address 0x26 resets to and reads 0xC5
// (R11) Writes ignored, values unchanged; mapped writes pulse regWriteIgnored
module port_controller_capability_regs (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	output logic [7:0] regRdData,
	output logic regRdValid,
	output logic regAddrHit,
	output logic regWriteIgnored,
	output logic [1:0] thresholdIgnoreMask,
	output logic [7:0] cableSupplyDeciwatts
);
	cap_field_if fields ();

	cap_byte_pack packer (
		.fields(fields.packer)
	);

	logic [7:0] capLowQ;
	logic [7:0] capHighQ;
	logic [7:0] stdInQ;
	logic [7:0] stdOutQ;
	logic [7:0] regRdDataQ;
	logic [7:0] regRdDataD;
	logic regRdValidQ;
	logic regAddrHitQ;
	logic regAddrHitD;
	logic regWriteIgnoredQ;
	logic [1:0] ignoreMaskQ;
	logic [7:0] deciwattsQ;
	logic [7:0] lastRdAddrQ;

	function automatic logic isMapped(input logic [7:0] addr);
		isMapped = (addr == cap_regs_pkg::CAP_TWO_LOW_ADDR) ||
			(addr == cap_regs_pkg::CAP_TWO_HIGH_ADDR) ||
			(addr == cap_regs_pkg::STD_IN_CAP_ADDR) ||
			(addr == cap_regs_pkg::STD_OUT_CAP_ADDR);
	endfunction : isMapped

	wire logic selLow;
	wire logic selHigh;
	wire logic selIn;
	wire logic selOut;
	wire logic [7:0] readMux;
	wire logic wrMapped;

	assign selLow = regAddr == cap_regs_pkg::CAP_TWO_LOW_ADDR;
	assign selHigh = regAddr == cap_regs_pkg::CAP_TWO_HIGH_ADDR;
	assign selIn = regAddr == cap_regs_pkg::STD_IN_CAP_ADDR;
	assign selOut = regAddr == cap_regs_pkg::STD_OUT_CAP_ADDR;
	assign readMux = selLow ? capLowQ :
		selHigh ? capHighQ :
		selIn ? stdInQ :
		selOut ? stdOutQ : cap_regs_pkg::READ_ZERO;
	assign regRdDataD = regRdEn ? readMux : regRdDataQ;
	assign regAddrHitD = regRdEn ? isMapped(regAddr) : regAddrHitQ;
	assign wrMapped = regWrEn && isMapped(regAddr); // [R11]

	// Register contents: loaded at reset, then refreshed only from fixed fields (low, input) or reset constants (high, output)
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			capLowQ <= cap_regs_pkg::CAP_TWO_LOW_RESET; // [R10]
			capHighQ <= cap_regs_pkg::CAP_TWO_HIGH_RESET; // [R7]
			stdInQ <= cap_regs_pkg::STD_IN_CAP_RESET; // [R8]
			stdOutQ <= cap_regs_pkg::STD_OUT_CAP_RESET; // [R9]
		end else begin
			capLowQ <= fields.capLowByte; // [R10] [R11]
			capHighQ <= cap_regs_pkg::CAP_TWO_HIGH_RESET; // [R7]
			stdInQ <= fields.stdInByte; // [R8]
			stdOutQ <= cap_regs_pkg::STD_OUT_CAP_RESET; // [R9]
		end
	end

	// Read port and status outputs
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			regRdDataQ <= cap_regs_pkg::READ_ZERO;
			regRdValidQ <= 1'b0;
			regAddrHitQ <= 1'b0;
			regWriteIgnoredQ <= 1'b0;
			ignoreMaskQ <= cap_regs_pkg::IGNORE_NONE;
			deciwattsQ <= cap_regs_pkg::READ_ZERO;
			lastRdAddrQ <= cap_regs_pkg::READ_ZERO;
		end else begin
			regRdDataQ <= regRdDataD;
			regRdValidQ <= regRdEn;
			regAddrHitQ <= regAddrHitD;
			regWriteIgnoredQ <= wrMapped; // [R11]
			ignoreMaskQ <= fields.ignoreMask; // [R4]
			deciwattsQ <= fields.deciwatts; // [R5]
			lastRdAddrQ <= regRdEn ? regAddr : lastRdAddrQ;
		end
	end

	assign regRdData = regRdDataQ;
	assign regRdValid = regRdValidQ;
	assign regAddrHit = regAddrHitQ;
	assign regWriteIgnored = regWriteIgnoredQ;
	assign thresholdIgnoreMask = ignoreMaskQ;
	assign cableSupplyDeciwatts = deciwattsQ;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	// Request and answer shapes on the register port
	sequence rdLow;
		regRdEn && !regWrEn && (regAddr == cap_regs_pkg::CAP_TWO_LOW_ADDR);
	endsequence
	sequence wrLow;
		regWrEn && (regAddr == cap_regs_pkg::CAP_TWO_LOW_ADDR)
			&& (regWrData != cap_regs_pkg::CAP_TWO_LOW_RESET);
	endsequence
	sequence lowAnswered;
		regRdValid && (lastRdAddrQ == cap_regs_pkg::CAP_TWO_LOW_ADDR);
	endsequence
	sequence rdHigh;
		regRdEn && (regAddr == cap_regs_pkg::CAP_TWO_HIGH_ADDR);
	endsequence
	sequence rdStdIn;
		regRdEn && (regAddr == cap_regs_pkg::STD_IN_CAP_ADDR);
	endsequence
	sequence rdStdOut;
		regRdEn && (regAddr == cap_regs_pkg::STD_OUT_CAP_ADDR);
	endsequence
	sequence zeroAnswer;
		regRdValid && regAddrHit && (regRdData == 8'h00);
	endsequence
	sequence portIdle;
		!regRdEn && !regWrEn;
	endsequence

	// One bit of the low byte answer
	property lowBit(int pos, logic val);
		lowAnswered |-> (regRdData[pos] == val);
	endproperty

	// Fields of the low capability byte
	a_sink_disc_bit: assert property (lowBit(cap_regs_pkg::SINK_DISC_BIT, 1'b1)) // [R1]
		else $error("Sink disconnect capability bit not set");
	a_stop_disch_bit: assert property (lowBit(cap_regs_pkg::STOP_DISCH_BIT, 1'b1)) // [R2]
		else $error("Stop discharge capability bit not set");
	a_alarm_step_field: assert property (lowAnswered |-> // [R3]
		regRdData[cap_regs_pkg::ALARM_STEP_HI:cap_regs_pkg::ALARM_STEP_LO] == 2'b00)
		else $error("Alarm step field not 25 mV");
	a_ignore_mask_none: assert property ((thresholdIgnoreMask == 2'h0) [*2]) // [R4]
		else $error("Alarm threshold bits ignored at 25 mV step");
	a_power_class_field: assert property (lowAnswered |-> // [R5]
		regRdData[cap_regs_pkg::POWER_CLASS_HI:cap_regs_pkg::POWER_CLASS_LO] == 3'b010
		&& cableSupplyDeciwatts == 8'h14)
		else $error("Supply switch power class not 2 W");
	a_oc_capable_bit: assert property (lowBit(cap_regs_pkg::OC_CAPABLE_BIT, 1'b1)) // [R6]
		else $error("Overcurrent capability bit not set");
	a_rating_steady: assert property (!$fell(sys_rst) |-> // [R5]
		cableSupplyDeciwatts == 8'h14)
		else $error("Supply switch rating output not 2 W");

	// Fixed zero registers and the low byte value
	a_high_byte_zero: assert property (rdHigh |=> zeroAnswer) // [R7]
		else $error("Capability high byte not zero");
	a_std_in_zero: assert property (rdStdIn |=> zeroAnswer) // [R8]
		else $error("Standard input capability not zero");
	a_std_in_bits: assert property (rdStdIn |=> // [R8]
		regRdData[cap_regs_pkg::EXT_OVERVOLT_BIT] == 1'b0
		&& regRdData[cap_regs_pkg::EXT_OVERCUR_BIT] == 1'b0
		&& regRdData[cap_regs_pkg::EXT_CUT_BIT] == 1'b0)
		else $error("External input reported as present");
	a_std_out_zero: assert property (rdStdOut |=> zeroAnswer ##1 // [R9]
		($stable(regRdData) || $past(regRdEn)))
		else $error("Standard output capability not zero");
	a_low_byte_value: assert property (rdLow |=> regRdValid && regAddrHit // [R10]
		&& regRdData == cap_regs_pkg::CAP_TWO_LOW_RESET)
		else $error("Capability low byte not 0xC5");
	a_low_read_hold: assert property (rdLow ##1 portIdle |=> !regRdValid // [R10]
		&& regRdData == cap_regs_pkg::CAP_TWO_LOW_RESET)
		else $error("Capability low byte not held after read");
	a_low_after_reset: assert property ($fell(sys_rst) |-> // [R10]
		capLowQ == cap_regs_pkg::CAP_TWO_LOW_RESET)
		else $error("Capability low byte wrong after reset");
	a_low_byte_fixed: assert property (capLowQ == cap_regs_pkg::CAP_TWO_LOW_RESET) // [R10]
		else $error("Capability low byte changed");

	// Port timing and ignored writes
	a_read_valid_pulse: assert property (regRdEn |=> regRdValid)
		else $error("Read answer missing");
	a_valid_idle_low: assert property (!regRdEn |=> !regRdValid)
		else $error("Read answer without request");
	a_read_data_holds: assert property (!regRdEn |=>
		$stable(regRdData) && $stable(regAddrHit))
		else $error("Read data changed without a read");
	a_hit_mapped: assert property (regRdEn && isMapped(regAddr) |=> regAddrHit)
		else $error("Mapped read not flagged as hit");
	a_unmapped_zero: assert property (regRdEn && !isMapped(regAddr)
		|=> !regAddrHit && regRdData == 8'h00)
		else $error("Unmapped read did not return zero");
	a_write_ignored: assert property (wrLow ##1 rdLow |=> // [R11]
		regRdData == cap_regs_pkg::CAP_TWO_LOW_RESET && $past(regWriteIgnored))
		else $error("Write altered capability low byte");
	a_write_pulse_mapped: assert property (regWrEn && isMapped(regAddr) // [R11]
		|=> regWriteIgnored)
		else $error("Mapped write not acknowledged as ignored");
	a_write_quiet_unmapped: assert property (regWrEn && !isMapped(regAddr) // [R11]
		|=> !regWriteIgnored)
		else $error("Unmapped write raised the ignored pulse");
	a_write_no_answer: assert property (regWrEn && !regRdEn |=> !regRdValid) // [R11]
		else $error("Write produced a read answer");
endmodule : port_controller_capability_regs

//--- dv/cap_host_model.sv
// Port manager host model driving the byte register port
`timescale 1ns/1ns
module cap_host_model (
	input wire logic ref_clk,
	output logic [7:0] regAddr,
	output logic [7:0] regWrData,
	output logic regWrEn,
	output logic regRdEn,
	input wire logic [7:0] regRdData,
	input wire logic regRdValid,
	input wire logic regWriteIgnored
);
	initial begin
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
	end

	// Released address and data lines show the inverse of the last value; both enables drop low
	task automatic release_bus();
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		regAddr = ~regAddr;
		regWrData = ~regWrData;
	endtask : release_bus

	// One access, answer sampled in the cycle after the request edge
	task automatic access(input logic [7:0] a, input logic rd, input logic wr,
		output logic [7:0] d, output logic v, output logic ign);
		@(posedge ref_clk);
		#5;
		regAddr = a;
		regWrData = 8'hff;
		regRdEn = rd;
		regWrEn = wr;
		@(posedge ref_clk);
		#5;
		release_bus();
		d = regRdData;
		v = regRdValid;
		ign = regWriteIgnored;
	endtask : access

	// Two reads on consecutive cycles
	task automatic read_pair(input logic [7:0] a0, input logic [7:0] a1,
		output logic [7:0] d0, output logic [7:0] d1);
		@(posedge ref_clk);
		#5;
		regAddr = a0;
		regRdEn = 1'b1;
		@(posedge ref_clk);
		#5;
		regAddr = a1;
		d0 = regRdData;
		@(posedge ref_clk);
		#5;
		release_bus();
		d1 = regRdData;
	endtask : read_pair

	// Write then read of one address on consecutive cycles
	task automatic write_read(input logic [7:0] a, output logic [7:0] d, output logic ign);
		@(posedge ref_clk);
		#5;
		regAddr = a;
		regWrData = 8'hff;
		regWrEn = 1'b1;
		@(posedge ref_clk);
		#5;
		regWrEn = 1'b0;
		regRdEn = 1'b1;
		ign = regWriteIgnored;
		@(posedge ref_clk);
		#5;
		release_bus();
		d = regRdData;
	endtask : write_read
endmodule : cap_host_model

//--- dv/port_controller_capability_regs_tb_top.sv
// Testbench for the read-only capability register bank
`timescale 1ns/1ns
module port_controller_capability_regs_tb_top;
	typedef struct {logic [7:0] addr; logic [7:0] data; logic hit;} row_s;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] regAddr, regWrData, regRdData, cableSupplyDeciwatts, d, d1;
	logic regWrEn, regRdEn, regRdValid, regAddrHit, regWriteIgnored, v, ign;
	logic [1:0] thresholdIgnoreMask;
	int bad_count = 0;
	int checks_done = 0;
	row_s rows [6] = '{'{8'h26, 8'hc5, 1'b1}, '{8'h27, 8'h00, 1'b1}, '{8'h28, 8'h00, 1'b1},
		'{8'h29, 8'h00, 1'b1}, '{8'h25, 8'h00, 1'b0}, '{8'h2a, 8'h00, 1'b0}};

	port_controller_capability_regs u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regRdData(regRdData), .regRdValid(regRdValid), .regAddrHit(regAddrHit),
		.regWriteIgnored(regWriteIgnored), .thresholdIgnoreMask(thresholdIgnoreMask),
		.cableSupplyDeciwatts(cableSupplyDeciwatts));
	cap_host_model u_host (.ref_clk(ref_clk), .regAddr(regAddr), .regWrData(regWrData),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
		.regRdValid(regRdValid), .regWriteIgnored(regWriteIgnored));

	initial begin
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask : check

	task automatic complete_run();
		$display("Mismatches %0d, comparisons %0d", bad_count, checks_done);
		if (bad_count == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : complete_run

	initial begin
		#200000;
		bad_count++;
		complete_run();
	end

	initial begin
		repeat (16) @(posedge ref_clk);
		#5;
		check(regRdData, 8'h00, "reset read data");
		check({7'h00, regRdValid}, 8'h00, "reset valid");
		check(cableSupplyDeciwatts, 8'h00, "reset rating");
		sys_rst = 1'b0;
		@(posedge ref_clk);
		#5;
		check(cableSupplyDeciwatts, 8'h14, "supply rating 2 W");
		check({6'h00, thresholdIgnoreMask}, 8'h00, "alarm skip mask");
		for (int p = 0; p < 2; p++) begin
			foreach (rows[i]) begin
				u_host.access(rows[i].addr, 1'b1, 1'b0, d, v, ign);
				check(d, rows[i].data, "read value");
				check({7'h00, v}, 8'h01, "read valid");
				check({7'h00, regAddrHit}, {7'h00, rows[i].hit}, "address hit");
			end
			foreach (rows[i]) begin
				u_host.access(rows[i].addr, 1'b0, 1'b1, d, v, ign);
				check({7'h00, ign}, {7'h00, rows[i].hit}, "write ignored pulse");
			end
		end
		u_host.access(8'h26, 1'b1, 1'b0, d, v, ign);
		check({7'h00, d[7]}, 8'h01, "sink disconnect bit");
		check({7'h00, d[6]}, 8'h01, "stop discharge bit");
		check({6'h00, d[5:4]}, 8'h00, "alarm step field");
		check({5'h00, d[3:1]}, 8'h02, "power class field");
		check({7'h00, d[0]}, 8'h01, "overcurrent bit");
		@(posedge ref_clk);
		#5;
		check({7'h00, regRdValid}, 8'h00, "valid one cycle");
		check(regRdData, 8'hc5, "read data holds");
		u_host.access(8'h27, 1'b1, 1'b1, d, v, ign);
		check(d, 8'h00, "read with write");
		check({7'h00, ign}, 8'h01, "write pulse with read");
		u_host.read_pair(8'h26, 8'h28, d, d1);
		check(d, 8'hc5, "first of pair");
		check(d1, 8'h00, "second of pair");
		u_host.write_read(8'h26, d, ign);
		check({7'h00, ign}, 8'h01, "write pulse before read");
		check(d, 8'hc5, "read right after write");
		sys_rst = 1'b1;
		@(posedge ref_clk);
		#5;
		check(regRdData, 8'h00, "second reset data");
		check({7'h00, regRdValid}, 8'h00, "second reset valid");
		check(cableSupplyDeciwatts, 8'h00, "second reset rating");
		sys_rst = 1'b0;
		u_host.access(8'h26, 1'b1, 1'b0, d, v, ign);
		check(d, 8'hc5, "value after reset");
		check(cableSupplyDeciwatts, 8'h14, "rating after second reset");
		complete_run();
	end
endmodule : port_controller_capability_regs_tb_top
